/* include/qdsc_defs.vh */
// constants for the quad dac serial command interface
`ifndef QDSC_DEFS_VH
`define QDSC_DEFS_VH
`define QDSC_WORD_BITS     12
`define QDSC_DATA_BITS     8
`define QDSC_CHANNELS      4
`define QDSC_ADDR_HI_POS   11
`define QDSC_ADDR_LO_POS   10
`define QDSC_CTRL_HI_POS   9
`define QDSC_CTRL_LO_POS   8
`define QDSC_DATA_MSB_POS  7
`define QDSC_CTRL_ALL      2'h0
`define QDSC_CTRL_INPUT    2'h1
`define QDSC_CTRL_XFER     2'h2
`define QDSC_CTRL_BOTH     2'h3
`define QDSC_ADDR_RISE     2'h3
`define QDSC_ADDR_FALL     2'h2
`define QDSC_ZERO_CODE     8'h00
`define QDSC_ZERO_WORD     12'h000
`define QDSC_FIFO_DEPTH    32
`define QDSC_SCLK_MAX_KHZ  12500
`define QDSC_CLK_KHZ       100000
`endif

/* hdl/qdsc_fifo.v */
// parameterised synchronous fifo for received command words, decoded after they leave it
`timescale 1ns/1ps
module qdsc_fifo #(
	parameter WIDTH = 12,
	parameter DEPTH = 32,
	parameter AW    = 5
) (
	input  wire             core_clk,
	input  wire             srst,
	input  wire [WIDTH-1:0] inData,
	input  wire             inValid,
	output wire             inReady,
	output wire [WIDTH-1:0] outData,
	output wire             outValid,
	input  wire             outReady
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW:0]      wrPtr_q;
	reg [AW:0]      rdPtr_q;
	wire            fullW;
	wire            emptyW;
	wire            doWr;
	wire            doRd;

	assign emptyW   = (wrPtr_q == rdPtr_q);
	assign fullW    = (wrPtr_q[AW] != rdPtr_q[AW]) && (wrPtr_q[AW-1:0] == rdPtr_q[AW-1:0]);
	assign inReady  = ~fullW;
	assign outValid = ~emptyW;
	assign outData  = mem[rdPtr_q[AW-1:0]];
	assign doWr     = inValid & ~fullW;
	assign doRd     = outReady & ~emptyW;

	always @(posedge core_clk) begin
		if (doWr) begin
			mem[wrPtr_q[AW-1:0]] <= inData;
		end
	end

	always @(posedge core_clk) begin
		if (srst) begin
			wrPtr_q <= {(AW+1){1'b0}};
			rdPtr_q <= {(AW+1){1'b0}};
		end else begin
			if (doWr) begin
				wrPtr_q <= wrPtr_q + 1'b1;
			end
			if (doRd) begin
				rdPtr_q <= rdPtr_q + 1'b1;
			end
		end
	end
endmodule

/* hdl/qdsc_serial_dac_if.v */
// serial command interface of a quad 8-bit dac, sampled in the core clock domain
// Notes on behaviour
// - reset clears shifter, input and dac registers, selects rising-edge output timing
// - command is 12 bits msb first; leading extra bits of longer words drop out
// - serial input sampled on each serial clock rise while chip select low
// - serial output is shifter content 12 clocks late, rising or falling edge
// - chip select high: clock and input ignored, output held and always driven
// - word order: two address bits, two control bits, eight data bits msb first
// - code 01 loads addressed input register only
// - code 11 loads addressed input and dac registers
// - code 00 with low address 0 loads data into all dac registers
// - code 00 with low address 1 is pass-through, nothing changes
// - code 10 with high address 0 transfers all input registers to dac registers
// - code 10 address 11 selects rising-edge output and transfers all
// - code 10 address 10 selects falling-edge output and transfers all
// - command captured only at chip select rising edge, then decoded and executed in order from the fifo
// - load strobe low makes dac registers follow input registers
// - clear low zeroes all input and dac registers at once
// - output phase stays latched until reset or opposite phase command
`timescale 1ns/1ps
`include "qdsc_defs.vh"
module qdsc_serial_dac_if #(
	parameter WORD_BITS  = `QDSC_WORD_BITS,
	parameter DATA_BITS  = `QDSC_DATA_BITS,
	parameter FIFO_DEPTH = `QDSC_FIFO_DEPTH
) (
	input  wire                 core_clk,
	input  wire                 srst,
	input  wire                 sclk,
	input  wire                 chipSelN,
	input  wire                 serialIn,
	input  wire                 loadDacStrobeN,
	input  wire                 asyncClearN,
	output reg                  serialOut,
	output reg                  serialOutEn,
	output reg  [DATA_BITS-1:0] dacCodeA,
	output reg  [DATA_BITS-1:0] dacCodeB,
	output reg  [DATA_BITS-1:0] dacCodeC,
	output reg  [DATA_BITS-1:0] dacCodeD,
	output reg                  outFallingMode,
	output reg                  cmdOverflow
);
	localparam OP_NONE  = 3'h0;
	localparam OP_INPUT = 3'h1;
	localparam OP_BOTH  = 3'h2;
	localparam OP_ALL   = 3'h3;
	localparam OP_PASS  = 3'h4;
	localparam OP_XFER  = 3'h5;
	localparam OP_RISE  = 3'h6;
	localparam OP_FALL  = 3'h7;
	localparam FIFO_AW  = $clog2(FIFO_DEPTH);

	// two-flop synchronisers; first stage read only by the second
	reg [2:0] sclkSync_q;
	reg [2:0] csSync_q;
	reg [1:0] dinSync_q;
	reg [1:0] ldacSync_q;
	reg [1:0] clrSync_q;

	reg [WORD_BITS-1:0] shift_q;
	reg                 pendOut_q;
	reg [DATA_BITS-1:0] inReg_q  [0:`QDSC_CHANNELS-1];
	reg [DATA_BITS-1:0] dacReg_q [0:`QDSC_CHANNELS-1];

	wire sclkRise;
	wire sclkFall;
	wire csRise;
	wire csLow;
	wire clrActive;
	wire ldacLow;
	wire shiftEn;

	wire [WORD_BITS-1:0] fifoOut;
	wire                 fifoValid;
	wire                 fifoReady;

	assign sclkRise  = sclkSync_q[1] & ~sclkSync_q[2];
	assign sclkFall  = ~sclkSync_q[1] & sclkSync_q[2];
	assign csRise    = csSync_q[1] & ~csSync_q[2];
	assign csLow     = ~csSync_q[1];
	assign clrActive = ~clrSync_q[1];
	assign ldacLow   = ~ldacSync_q[1];
	assign shiftEn   = csLow & sclkRise;

	function [`QDSC_CHANNELS-1:0] chanSel;
		input [1:0] addr;
		begin
			chanSel = {{(`QDSC_CHANNELS-1){1'b0}}, 1'b1} << addr;
		end
	endfunction

	// one decode for every command kind
	function [2:0] decodeOp;
		input [1:0] ctrl;
		input [1:0] addr;
		begin
			case (ctrl)
				`QDSC_CTRL_INPUT: begin
					decodeOp = OP_INPUT;
				end
				`QDSC_CTRL_BOTH: begin
					decodeOp = OP_BOTH;
				end
				`QDSC_CTRL_ALL: begin
					if (addr[0]) begin
						decodeOp = OP_PASS;
					end else begin
						decodeOp = OP_ALL;
					end
				end
				`QDSC_CTRL_XFER: begin
					if (addr == `QDSC_ADDR_RISE) begin
						decodeOp = OP_RISE;
					end else if (addr == `QDSC_ADDR_FALL) begin
						decodeOp = OP_FALL;
					end else begin
						decodeOp = OP_XFER;
					end
				end
				default: begin
					decodeOp = OP_NONE;
				end
			endcase
		end
	endfunction

	// extra stage on clock and select gives a registered copy for edge detection
	always @(posedge core_clk) begin
		if (srst) begin
			sclkSync_q <= 3'h0;
			csSync_q   <= 3'h7;
		end else begin
			sclkSync_q <= {sclkSync_q[1:0], sclk};
			csSync_q   <= {csSync_q[1:0], chipSelN};
		end
	end

	// idle levels on reset so no false strobe or clear follows it
	always @(posedge core_clk) begin
		if (srst) begin
			dinSync_q  <= 2'h0;
			ldacSync_q <= 2'h3;
			clrSync_q  <= 2'h3;
		end else begin
			dinSync_q  <= {dinSync_q[0], serialIn};
			ldacSync_q <= {ldacSync_q[0], loadDacStrobeN};
			clrSync_q  <= {clrSync_q[0], asyncClearN};
		end
	end

	// shifter; last 12 bits win on overlong frames
	always @(posedge core_clk) begin
		if (srst) begin
			shift_q <= `QDSC_ZERO_WORD;
		end else if (shiftEn) begin
			shift_q <= {shift_q[WORD_BITS-2:0], dinSync_q[1]};
		end
	end

	// bit leaving the shifter waits here for a falling-edge launch
	always @(posedge core_clk) begin
		if (srst) begin
			pendOut_q <= 1'b0;
		end else if (shiftEn) begin
			pendOut_q <= shift_q[WORD_BITS-1];
		end
	end

	always @(posedge core_clk) begin
		if (srst) begin
			serialOut <= 1'b0;
		end else if (shiftEn && !outFallingMode) begin
			serialOut <= shift_q[WORD_BITS-1];
		end else if (csLow && sclkFall && outFallingMode) begin
			serialOut <= pendOut_q;
		end
	end

	// pin is never released, so the enable rises once reset is gone
	always @(posedge core_clk) begin
		if (srst) begin
			serialOutEn <= 1'b0;
		end else begin
			serialOutEn <= 1'b1;
		end
	end

	// frames hand their word to the executor through the fifo
	qdsc_fifo #(
		.WIDTH (WORD_BITS),
		.DEPTH (FIFO_DEPTH),
		.AW    (FIFO_AW)
	) cmdFifo (
		.core_clk (core_clk),
		.srst     (srst),
		.inData   (shift_q),
		.inValid  (csRise),
		.inReady  (fifoReady),
		.outData  (fifoOut),
		.outValid (fifoValid),
		.outReady (~clrActive)
	);

	wire [1:0]           cmdAddr = fifoOut[`QDSC_ADDR_HI_POS:`QDSC_ADDR_LO_POS];
	wire [1:0]           cmdCtrl = fifoOut[`QDSC_CTRL_HI_POS:`QDSC_CTRL_LO_POS];
	wire [DATA_BITS-1:0] cmdData = fifoOut[`QDSC_DATA_MSB_POS:0];
	wire                 doCmd   = fifoValid & ~clrActive;

	// one decoded command per cycle; clear empties this stage only, words held in the fifo run after it
	reg [2:0]                 execOp_q;
	reg [1:0]                 execAddr_q;
	reg [DATA_BITS-1:0]       execData_q;
	wire [`QDSC_CHANNELS-1:0] selW    = chanSel(execAddr_q);
	wire                      opInput = (execOp_q == OP_INPUT);
	wire                      opBoth  = (execOp_q == OP_BOTH);
	wire                      opAll   = (execOp_q == OP_ALL);
	wire                      opXfer  = (execOp_q == OP_XFER) || (execOp_q == OP_RISE) || (execOp_q == OP_FALL);

	always @(posedge core_clk) begin
		if (srst || clrActive) begin
			execOp_q   <= OP_NONE;
			execAddr_q <= 2'h0;
			execData_q <= `QDSC_ZERO_CODE;
		end else if (doCmd) begin
			execOp_q   <= decodeOp(cmdCtrl, cmdAddr);
			execAddr_q <= cmdAddr;
			execData_q <= cmdData;
		end else begin
			execOp_q   <= OP_NONE;
		end
	end

	always @(posedge core_clk) begin
		if (srst) begin
			cmdOverflow <= 1'b0;
		end else if (csRise && !fifoReady) begin
			cmdOverflow <= 1'b1;
		end
	end

	always @(posedge core_clk) begin
		if (srst) begin
			outFallingMode <= 1'b0;
		end else if (execOp_q == OP_RISE) begin
			outFallingMode <= 1'b0;
		end else if (execOp_q == OP_FALL) begin
			outFallingMode <= 1'b1;
		end
	end

	genvar ch;
	generate
		for (ch = 0; ch < `QDSC_CHANNELS; ch = ch + 1) begin : gChan
			wire                 inWe   = selW[ch] && (opInput || opBoth);
			wire [DATA_BITS-1:0] inNext = inWe ? execData_q : inReg_q[ch];
			always @(posedge core_clk) begin
				if (srst || clrActive) begin
					inReg_q[ch] <= `QDSC_ZERO_CODE;
				end else begin
					inReg_q[ch] <= inNext;
				end
			end
			// strobe low wins over command loads so the dac never lags its input register
			always @(posedge core_clk) begin
				if (srst || clrActive) begin
					dacReg_q[ch] <= `QDSC_ZERO_CODE;
				end else if (ldacLow) begin
					dacReg_q[ch] <= inNext;
				end else if (opBoth && selW[ch]) begin
					dacReg_q[ch] <= execData_q;
				end else if (opAll) begin
					dacReg_q[ch] <= execData_q;
				end else if (opXfer) begin
					dacReg_q[ch] <= inReg_q[ch];
				end
			end
		end
	endgenerate

	always @(posedge core_clk) begin
		if (srst) begin
			dacCodeA <= `QDSC_ZERO_CODE;
		end else begin
			dacCodeA <= dacReg_q[0];
		end
	end

	always @(posedge core_clk) begin
		if (srst) begin
			dacCodeB <= `QDSC_ZERO_CODE;
		end else begin
			dacCodeB <= dacReg_q[1];
		end
	end

	always @(posedge core_clk) begin
		if (srst) begin
			dacCodeC <= `QDSC_ZERO_CODE;
		end else begin
			dacCodeC <= dacReg_q[2];
		end
	end

	always @(posedge core_clk) begin
		if (srst) begin
			dacCodeD <= `QDSC_ZERO_CODE;
		end else begin
			dacCodeD <= dacReg_q[3];
		end
	end
endmodule

/* tb/qdsc_asserts.sv */
// concurrent checks on the serial dac interface ports
`timescale 1ns/1ps
module qdsc_asserts (
	input logic       core_clk,
	input logic       srst,
	input logic       sclk,
	input logic       chipSelN,
	input logic       serialIn,
	input logic       loadDacStrobeN,
	input logic       asyncClearN,
	input logic       serialOut,
	input logic       serialOutEn,
	input logic [7:0] dacCodeA,
	input logic [7:0] dacCodeB,
	input logic [7:0] dacCodeC,
	input logic [7:0] dacCodeD,
	input logic       outFallingMode,
	input logic       cmdOverflow
);
	wire [31:0] codes = {dacCodeA, dacCodeB, dacCodeC, dacCodeD};
	default clocking @(posedge core_clk); endclocking
	a_reset_codes: assert property ($past(srst) |-> codes == 32'h0000_0000) else $error("codes after reset");
	a_reset_mode: assert property ($past(srst) |-> !outFallingMode) else $error("mode after reset");
	a_out_driven: assert property (!srst && !$past(srst) |-> serialOutEn) else $error("output undriven");
	a_clear_zero: assert property (disable iff (srst) !asyncClearN [*5] |-> codes == 32'h0000_0000)
		else $error("clear ignored");
	a_idle_out_held: assert property (disable iff (srst) chipSelN [*5] |-> $stable(serialOut))
		else $error("output moved while idle");
	a_frame_no_exec: assert property (disable iff (srst) (!chipSelN && asyncClearN) [*8] |-> $stable(codes))
		else $error("code changed mid frame");
	a_mode_at_idle: assert property (disable iff (srst) $changed(outFallingMode) |-> chipSelN)
		else $error("mode changed mid frame");
	a_out_edge_phase: assert property (disable iff (srst) $changed(serialOut) |-> $past(sclk, 2) != outFallingMode)
		else $error("output on wrong edge");
	cover property (outFallingMode);
	cover property (cmdOverflow);
	cover property (!asyncClearN [*5]);
endmodule
bind qdsc_serial_dac_if qdsc_asserts u_chk (.*);

/* tb/qdsc_host_model.sv */
// serial host model that shifts command frames into the dac
`timescale 1ns/1ps
module qdsc_host_model (
	output logic sclk,
	output logic chipSelN,
	output logic serialIn
);
	initial begin
		sclk = 1'h0;
		chipSelN = 1'h1;
		serialIn = 1'h0;
	end
	task automatic send(input logic [31:0] w, input int n);
		// step off the core clock edge the caller woke on
		#1 chipSelN = 1'h0;
		#50;
		for (int i = n - 1; i >= 0; i--) begin
			serialIn = w[i];
			#62.5 sclk = 1'h1;
			#62.5 sclk = 1'h0;
		end
		#50 chipSelN = 1'h1;
		// released line must not look like a held bit
		serialIn = ~serialIn;
		#300;
	endtask
endmodule

/* tb/qdsc_serial_dac_if_tb.sv */
// self-checking bench for the serial dac command interface
`timescale 1ns/1ps
module qdsc_serial_dac_if_tb;
	logic       core_clk = 1'h0;
	logic       srst = 1'h1;
	logic       loadDacStrobeN = 1'h1;
	logic       asyncClearN = 1'h1;
	wire        sclk, chipSelN, serialIn, serialOut, serialOutEn, outFallingMode, cmdOverflow;
	wire  [7:0] dacCodeA, dacCodeB, dacCodeC, dacCodeD;
	wire [31:0] codes = {dacCodeA, dacCodeB, dacCodeC, dacCodeD};
	int         miscompares = 0;
	int         compares = 0;
	always #5 core_clk = ~core_clk;
	qdsc_host_model host (.*);
	qdsc_serial_dac_if dut (.*);
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cmd(input logic [1:0] a, input logic [1:0] c, input logic [7:0] d);
		host.send({4'h0, a, c, d}, 12);
	endtask
	task automatic print_verdict();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (compares > 0 && miscompares == 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		#300000;
		miscompares++;
		print_verdict();
	end
	initial begin
		repeat (10) @(posedge core_clk);
		srst <= 1'h0;
		repeat (3) @(posedge core_clk);
		chk(codes, 32'h0000_0000);
		chk(32'(outFallingMode), 32'h0000_0000);
		chk(32'(serialOutEn), 32'h0000_0001);
		cmd(2'h0, 2'h1, 8'h5a);
		chk(codes, 32'h0000_0000);
		cmd(2'h1, 2'h3, 8'hc3);
		chk(codes, 32'h00c3_0000);
		cmd(2'h1, 2'h2, 8'h00);
		chk(codes, 32'h5ac3_0000);
		cmd(2'h2, 2'h0, 8'h11);
		chk(codes, 32'h1111_1111);
		cmd(2'h1, 2'h0, 8'hff);
		chk(codes, 32'h1111_1111);
		chk(32'(serialOut), 32'h0000_0001);
		host.send(32'h0039_8400, 24);
		chk(codes, 32'h1111_1111);
		chk(32'(serialOut), 32'h0000_0000);
		host.send({4'hf, 2'h3, 2'h3, 8'h77}, 16);
		chk(codes, 32'h1111_1177);
		cmd(2'h2, 2'h2, 8'h01);
		chk(codes, 32'h5ac3_0077);
		chk(32'(outFallingMode), 32'h0000_0001);
		cmd(2'h1, 2'h0, 8'h00);
		chk(32'(serialOut), 32'h0000_0001);
		cmd(2'h3, 2'h2, 8'h00);
		chk(32'(outFallingMode), 32'h0000_0000);
		cmd(2'h2, 2'h1, 8'h3c);
		chk(codes, 32'h5ac3_0077);
		@(posedge core_clk) loadDacStrobeN <= 1'h0;
		repeat (8) @(posedge core_clk);
		chk(codes, 32'h5ac3_3c77);
		@(posedge core_clk) loadDacStrobeN <= 1'h1;
		@(posedge core_clk) asyncClearN <= 1'h0;
		// stalled queue overflows past its depth
		repeat (35) cmd(2'h1, 2'h0, 8'h00);
		chk(codes, 32'h0000_0000);
		chk(32'(cmdOverflow), 32'h0000_0001);
		@(posedge core_clk) asyncClearN <= 1'h1;
		repeat (100) @(posedge core_clk);
		cmd(2'h0, 2'h3, 8'ha5);
		chk(codes, 32'ha500_0000);
		print_verdict();
	end
endmodule
